// File: ead_dev.sv
// Receive-side serial tap with external reject merge into frame acceptance.
`default_nettype none
// What this block does
// - Tap works only when select bit set.
// - Tap data and clock follow decoded stream.
// - Tap clock toggles only during frame reception and link reset.
// - Marker goes high after delimiter's two ones.
// - Marker then strobes every byte boundary.
// - Comparator pulls reject low to drop frame.
// - Internal address match accepts frame unless receive disable set.
// - Reject ignored from 64 bytes after delimiter.
// - Comparator has about 58 byte times.
// - Runt accept: reject before frame ends.
// - Reject low pulse lasts at least 200 ns.
// - Promiscuous mode accepts all unless receive disable set, ignores reject.
// - No internal filters: accept unrejected frames only.
// - Tap runs on start bit despite disables.
// - Reject within 512 bits keeps matches and promiscuous frames only.
module ead_dev (
  // System clock and reset.
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Register port.
  input  wire logic [ead_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ead_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ead_pkg::DATA_W-1:0] reg_rdata,
  // Decoded receive stream and internal address compare.
  input  wire logic                      rx_clk,
  input  wire logic                      rx_data,
  input  wire logic                      rx_active,
  input  wire logic                      rx_phys_match,
  input  wire logic                      rx_group_match,
  input  wire logic [ead_pkg::HASH_W-1:0] rx_hash_idx,
  // Frame decisions.
  output logic                           frame_done,
  output logic                           frame_accept,
  output logic                           transmit_disable,
  // Tap pins.
  ead_link_if.dev                        lnk
);
  import ead_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HUNT,
    ST_BODY
  } ead_state_e;

  // System domain.
  logic [CTRL_W-1:0]     ctrl_reg;
  logic [LAF_W-1:0]      laf_reg;
  logic [CNT_W-1:0]      acc_cnt_reg;
  logic [CNT_W-1:0]      rej_cnt_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic                  done_reg;
  logic                  accept_reg;
  logic                  txdis_reg;
  logic                  d_s1, d_s2, d_s3;

  // Link domain.
  logic                  lrst_s1, lrst_reg;
  logic [2:0]            cfg_s1, cfg_reg;
  logic [LAF_W-1:0]      laf_s1, laf_lreg;
  logic                  rej_s1, rej_s2;
  ead_state_e            state_reg, state_next;
  logic                  prev_reg;
  logic [BIT_CNT_W-1:0]  bit_reg;
  logic [BYTE_CNT_W-1:0] byte_reg;
  logic                  rej_seen_reg;
  logic                  match_reg;
  logic                  sdata_reg;
  logic                  marker_reg;
  logic                  gate_reg;
  logic                  dec_tgl_reg;
  logic                  dec_acc_reg;

  // Control decode, system side.
  wire ctl_start  = ctrl_reg[CTRL_START_BIT];
  wire ctl_sel    = ctrl_reg[CTRL_SEL_BIT];
  wire ctl_promiscuous_enable   = ctrl_reg[CTRL_PROMISCUOUS_ENABLE_BIT];
  wire ctl_disable_physical_addr_rx = ctrl_reg[CTRL_DISABLE_PHYSICAL_ADDR_RX_BIT];
  wire ctl_rxdis  = ctrl_reg[CTRL_RXDIS_BIT];
  wire ctl_txdis  = ctrl_reg[CTRL_TXDIS_BIT];

  // The receive and transmit disables are left out on purpose.
  wire tap_en_sys = ctl_sel && ctl_start;

  // Configuration crosses as slow levels; software changes it only while
  // the controller start bit is clear, so the multi-bit copy is coherent.
  always_ff @(posedge rx_clk) begin
    lrst_s1  <= sys_rst;
    lrst_reg <= lrst_s1;
    cfg_s1   <= {ctl_disable_physical_addr_rx, ctl_promiscuous_enable, tap_en_sys};
    cfg_reg  <= cfg_s1;
    laf_s1   <= laf_reg;
    laf_lreg <= laf_s1;
    rej_s1   <= lnk.external_reject_n;
    rej_s2   <= rej_s1;
  end

  wire l_en     = cfg_reg[0];
  wire l_promiscuous_enable   = cfg_reg[1];
  wire l_disable_physical_addr_rx = cfg_reg[2];

  // Link state machine.
  wire sfd_seen   = prev_reg && rx_data;
  wire byte_end   = (bit_reg == LAST_BIT);
  wire in_window  = (byte_reg < DECISION_BYTES);
  wire frame_end  = (state_reg == ST_BODY) && !rx_active;
  wire int_match  = (rx_phys_match && !l_disable_physical_addr_rx) ||
                    (rx_group_match && laf_lreg[rx_hash_idx]);
  wire rej_now    = !rej_s2 && l_en && in_window;
  // Internal match or promiscuous mode override any reject.
  wire accept_now = l_promiscuous_enable || match_reg || (l_en && !rej_seen_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rx_active) begin
          state_next = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (!rx_active) begin
          state_next = ST_IDLE;
        end else if (sfd_seen) begin
          state_next = ST_BODY;
        end
      end
      ST_BODY: begin
        if (!rx_active) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge rx_clk) begin
    if (lrst_reg) begin
      state_reg <= ST_IDLE;
      prev_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      prev_reg  <= rx_active && rx_data;
    end
  end

  always_ff @(posedge rx_clk) begin
    if (lrst_reg || state_reg != ST_BODY) begin
      bit_reg  <= '0;
      byte_reg <= '0;
    end else begin
      bit_reg <= bit_reg + 1'b1;
      if (byte_end && in_window) begin
        byte_reg <= byte_reg + 1'b1;
      end
    end
  end

  // Flags clear at the delimiter so a late reject of the last frame
  // cannot leak into the next one.
  always_ff @(posedge rx_clk) begin
    if (lrst_reg || state_reg == ST_HUNT) begin
      rej_seen_reg <= 1'b0;
      match_reg    <= 1'b0;
    end else if (state_reg == ST_BODY) begin
      if (rej_now) begin
        rej_seen_reg <= 1'b1;
      end
      if (int_match) begin
        match_reg <= 1'b1;
      end
    end
  end

  // The decision travels as a toggle with its result held beside it.
  always_ff @(posedge rx_clk) begin
    if (lrst_reg) begin
      dec_tgl_reg <= 1'b0;
      dec_acc_reg <= 1'b0;
    end else if (frame_end) begin
      dec_tgl_reg <= ~dec_tgl_reg;
      dec_acc_reg <= accept_now;
    end
  end

  // Tap outputs are launched on the rising edge and the tap clock is the
  // inverted receive clock, so the comparator samples mid-bit.
  always_ff @(posedge rx_clk) begin
    if (lrst_reg) begin
      sdata_reg  <= 1'b0;
      marker_reg <= 1'b0;
    end else begin
      sdata_reg  <= l_en && rx_data;
      // Gated by carrier so no stray marker follows the last full byte.
      marker_reg <= l_en && state_reg == ST_BODY && rx_active &&
                    bit_reg == '0;
    end
  end

  // The gate also runs during link reset so the far end can reset; the
  // gate only moves while the inverted clock is low, avoiding glitches.
  always_ff @(posedge rx_clk) begin
    gate_reg <= lrst_reg || (l_en && rx_active);
  end

  assign lnk.serial_rx_clock_out     = gate_reg && !rx_clk;
  assign lnk.serial_rx_data_out      = sdata_reg;
  assign lnk.frame_start_byte_marker = marker_reg;

  // System side: decision event and register file.
  always_ff @(posedge clk) begin
    d_s1 <= dec_tgl_reg;
    d_s2 <= d_s1;
    d_s3 <= d_s2;
  end

  wire dec_evt  = d_s2 ^ d_s3;
  wire take_acc = dec_evt && dec_acc_reg && !ctl_rxdis;
  wire take_rej = dec_evt && !take_acc;

  wire [DATA_W-1:0] rd_mux =
    (reg_addr == DEV_CTRL_OFS)   ? DATA_W'(ctrl_reg) :
    (reg_addr == DEV_LAF_LO_OFS) ? laf_reg[DATA_W-1:0] :
    (reg_addr == DEV_LAF_HI_OFS) ? laf_reg[LAF_W-1:DATA_W] :
    (reg_addr == DEV_STAT_OFS)   ? {rej_cnt_reg, acc_cnt_reg} : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
      laf_reg  <= '0;
    end else if (reg_wr) begin
      if (reg_addr == DEV_CTRL_OFS) begin
        ctrl_reg <= reg_wdata[CTRL_W-1:0];
      end
      if (reg_addr == DEV_LAF_LO_OFS) begin
        laf_reg[DATA_W-1:0] <= reg_wdata;
      end
      if (reg_addr == DEV_LAF_HI_OFS) begin
        laf_reg[LAF_W-1:DATA_W] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_cnt_reg <= '0;
      rej_cnt_reg <= '0;
      done_reg    <= 1'b0;
      accept_reg  <= 1'b0;
      txdis_reg   <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      if (take_acc) begin
        acc_cnt_reg <= acc_cnt_reg + 1'b1;
      end
      if (take_rej) begin
        rej_cnt_reg <= rej_cnt_reg + 1'b1;
      end
      done_reg   <= dec_evt;
      accept_reg <= take_acc;
      txdis_reg  <= ctl_txdis;
      rdata_reg  <= reg_rd ? rd_mux : '0;
    end
  end

  assign frame_done       = done_reg;
  assign frame_accept     = accept_reg;
  assign transmit_disable = txdis_reg;
  assign reg_rdata        = rdata_reg;
endmodule
`default_nettype wire

// File: ead_pkg.sv
// Shared constants for the external address detect tap and its comparator.
`default_nettype none
package ead_pkg;
  // Plain register port.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Serial stream framing.
  localparam int BYTE_BITS   = 8;
  localparam int BIT_CNT_W   = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int DECISION_BITS = 512;
  localparam int BYTE_CNT_W    = 7;
  localparam logic [BYTE_CNT_W-1:0] DECISION_BYTES =
    BYTE_CNT_W'(DECISION_BITS / BYTE_BITS);
  localparam int HASH_W = 6;
  localparam int LAF_W  = 64;
  localparam int CNT_W  = 16;
  // Device registers.
  localparam logic [ADDR_W-1:0] DEV_CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] DEV_LAF_LO_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] DEV_LAF_HI_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DEV_STAT_OFS   = 8'h0c;
  localparam int CTRL_W         = 16;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SEL_BIT   = 1;
  localparam int CTRL_RXDIS_BIT = 2;
  localparam int CTRL_TXDIS_BIT = 3;
  localparam int CTRL_DISABLE_PHYSICAL_ADDR_RX_BIT = 13;
  localparam int CTRL_PROMISCUOUS_ENABLE_BIT  = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  // Comparator registers.
  localparam logic [ADDR_W-1:0] EXT_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] EXT_STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] EXT_TBL_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] EXT_TBL_END  = 8'h30;
  localparam int EXT_EN_BIT   = 0;
  localparam int EXT_DENY_BIT = 1;
  localparam int TBL_ENTRIES  = 4;
  localparam int TBL_IDX_LSB  = 3;
  localparam int TBL_IDX_W    = 2;
  localparam int TBL_HI_BIT   = 2;
  localparam int MAC_W        = 48;
  localparam int MAC_HI_W     = MAC_W - DATA_W;
  localparam int TBL_VALID_BIT = MAC_HI_W;
  localparam int DA_BYTES     = 6;
  localparam int GAP_W        = 4;
  // Reject pulse width on the 20 MHz clock, rounded up.
  localparam int SYS_CLK_NS    = 50;
  localparam int REJECT_MIN_NS = 200;
  localparam int HOLD_W        = 4;
  localparam logic [HOLD_W-1:0] REJECT_HOLD_CYC =
    HOLD_W'((REJECT_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
endpackage
`default_nettype wire

// File: ead_link_if.sv
// Serial tap pins between the receive controller and external comparator.
`default_nettype none
interface ead_link_if;
  logic serial_rx_clock_out;
  logic serial_rx_data_out;
  logic frame_start_byte_marker;
  logic external_reject_n;
  modport dev (
    output serial_rx_clock_out,
    output serial_rx_data_out,
    output frame_start_byte_marker,
    input  external_reject_n
  );
  modport ext (
    input  serial_rx_clock_out,
    input  serial_rx_data_out,
    input  frame_start_byte_marker,
    output external_reject_n
  );
endinterface
`default_nettype wire

// File: ead_ext.sv
// External comparator: deserialises the destination and drives reject.
`default_nettype none
module ead_ext (
  // System clock and reset.
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Register port.
  input  wire logic [ead_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ead_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [ead_pkg::DATA_W-1:0] reg_rdata,
  // Decision event.
  output logic                           reject_pulse,
  // Tap pins.
  ead_link_if.ext                        lnk
);
  import ead_pkg::*;

  logic                  lclk;
  logic                  lrst_s1, lrst_reg;
  logic [GAP_W-1:0]      gap_reg;
  logic [2:0]            idx_reg;
  logic [BYTE_BITS-1:0]  shift_reg;
  logic [MAC_W-1:0]      da_reg;
  logic                  da_tgl_reg;
  logic                  t_s1, t_s2, t_s3;
  logic [1:0]            ctrl_reg;
  logic [CNT_W-1:0]      rej_cnt_reg;
  logic [HOLD_W-1:0]     hold_reg;
  logic                  rej_n_reg;
  logic                  pulse_reg;
  logic [DATA_W-1:0]     rdata_reg;
  logic [MAC_HI_W:0]     tbl_hi [TBL_ENTRIES];
  logic [DATA_W-1:0]     tbl_lo [TBL_ENTRIES];
  logic [TBL_ENTRIES-1:0] hit_vec;

  assign lclk = lnk.serial_rx_clock_out;

  // Link side: a marker after a long gap opens a frame.
  wire gap_full  = (gap_reg == {GAP_W{1'b1}});
  wire mark      = lnk.frame_start_byte_marker;
  wire new_frame = mark && (gap_reg > GAP_W'(LAST_BIT));
  wire byte_done = mark && (gap_reg == GAP_W'(LAST_BIT));
  wire take_byte = byte_done && (idx_reg < 3'(DA_BYTES));

  always_ff @(posedge lclk) begin
    lrst_s1  <= sys_rst;
    lrst_reg <= lrst_s1;
  end

  always_ff @(posedge lclk) begin
    if (lrst_reg) begin
      gap_reg    <= {GAP_W{1'b1}};
      idx_reg    <= 3'(DA_BYTES);
      shift_reg  <= '0;
      da_reg     <= '0;
      da_tgl_reg <= 1'b0;
    end else begin
      shift_reg <= {lnk.serial_rx_data_out, shift_reg[BYTE_BITS-1:1]};
      gap_reg   <= mark ? '0 : (gap_full ? gap_reg : gap_reg + 1'b1);
      if (new_frame) begin
        idx_reg <= '0;
      end else if (take_byte) begin
        da_reg[idx_reg*BYTE_BITS +: BYTE_BITS] <= shift_reg;
        idx_reg <= idx_reg + 1'b1;
        if (idx_reg == 3'(DA_BYTES - 1)) begin
          da_tgl_reg <= ~da_tgl_reg;
        end
      end
    end
  end

  // The captured address stays still until the next frame's first byte.
  generate
    for (genvar i = 0; i < TBL_ENTRIES; i++) begin : g_cmp
      assign hit_vec[i] = tbl_hi[i][TBL_VALID_BIT] &&
        (da_reg == {tbl_hi[i][MAC_HI_W-1:0], tbl_lo[i]});
    end
  endgenerate

  wire da_evt   = t_s2 ^ t_s3;
  wire any_hit  = |hit_vec;
  wire decide   = da_evt && ctrl_reg[EXT_EN_BIT] &&
                  (ctrl_reg[EXT_DENY_BIT] ? any_hit : !any_hit);
  wire [HOLD_W-1:0] hold_next = decide ? REJECT_HOLD_CYC :
    ((hold_reg != '0) ? hold_reg - 1'b1 : '0);

  wire in_tbl = (reg_addr >= EXT_TBL_BASE) && (reg_addr < EXT_TBL_END);
  wire [TBL_IDX_W-1:0] tidx = reg_addr[TBL_IDX_LSB +: TBL_IDX_W];
  wire t_hi = reg_addr[TBL_HI_BIT];
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == EXT_CTRL_OFS) ? DATA_W'(ctrl_reg) :
    (reg_addr == EXT_STAT_OFS) ? DATA_W'(rej_cnt_reg) :
    (in_tbl && t_hi)           ? DATA_W'(tbl_hi[tidx]) :
    in_tbl                     ? tbl_lo[tidx] : '0;

  always_ff @(posedge clk) begin
    t_s1 <= da_tgl_reg;
    t_s2 <= t_s1;
    t_s3 <= t_s2;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg    <= '0;
      rej_cnt_reg <= '0;
      hold_reg    <= '0;
      rej_n_reg   <= 1'b1;
      pulse_reg   <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      if (reg_wr && reg_addr == EXT_CTRL_OFS) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      if (decide) begin
        rej_cnt_reg <= rej_cnt_reg + 1'b1;
      end
      hold_reg  <= hold_next;
      rej_n_reg <= (hold_next == '0);
      pulse_reg <= decide;
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  // The table is plain storage; software fills it before enabling.
  always_ff @(posedge clk) begin
    if (reg_wr && in_tbl && t_hi) begin
      tbl_hi[tidx] <= reg_wdata[MAC_HI_W:0];
    end
    if (reg_wr && in_tbl && !t_hi) begin
      tbl_lo[tidx] <= reg_wdata;
    end
  end

  assign lnk.external_reject_n = rej_n_reg;
  assign reject_pulse          = pulse_reg;
  assign reg_rdata             = rdata_reg;
endmodule
`default_nettype wire

// File: ead_chk.sv
// Assertions on the tap pins between the receive end and the comparator.
`default_nettype none
module ead_chk (
  // Clocks and reset.
  input wire logic clk,
  input wire logic rx_clk,
  input wire logic sys_rst,
  // Decoded receive stream.
  input wire logic rx_data,
  input wire logic rx_active,
  // Tap pins.
  input wire logic serial_rx_clock_out,
  input wire logic serial_rx_data_out,
  input wire logic frame_start_byte_marker,
  input wire logic external_reject_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] idle_reg;
  logic [3:0] mark_reg;

  // Both counters saturate so a long idle spell or frame never wraps them.
  always_ff @(posedge rx_clk) begin
    if (sys_rst || rx_active) begin
      idle_reg <= 5'h00;
    end else if (idle_reg != 5'h1f) begin
      idle_reg <= idle_reg + 5'h01;
    end
  end

  always_ff @(posedge rx_clk) begin
    if (sys_rst || !rx_active) begin
      mark_reg <= 4'h0;
    end else if (frame_start_byte_marker && mark_reg != 4'hf) begin
      mark_reg <= mark_reg + 4'h1;
    end
  end

  sequence s_sfd_ones;
    $past(rx_data, 2) && $past(rx_data, 3);
  endsequence

  sequence s_byte_gap;
    (!frame_start_byte_marker) [*7];
  endsequence

  a_clock_gated: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_clk |-> !serial_rx_clock_out)
    else $error("tap clock high while recovered clock is high");
  a_clock_idle: assert property (
    @(posedge clk) disable iff (sys_rst)
    idle_reg >= 5'h10 |-> !serial_rx_clock_out)
    else $error("tap clock active outside a frame");
  a_data_follows: assert property (
    @(posedge rx_clk) disable iff (sys_rst)
    serial_rx_data_out |-> $past(rx_data))
    else $error("tap data does not follow the decoded stream");
  a_marker_after_sfd: assert property (
    @(posedge rx_clk) disable iff (sys_rst)
    frame_start_byte_marker && !$past(frame_start_byte_marker, 8)
    |-> s_sfd_ones)
    else $error("first marker not preceded by two ones");
  a_marker_spacing: assert property (
    @(posedge rx_clk) disable iff (sys_rst)
    frame_start_byte_marker |=> s_byte_gap ##1
    (frame_start_byte_marker || !$past(rx_active)))
    else $error("byte marker not every eighth bit");
  a_marker_in_frame: assert property (
    @(posedge rx_clk) disable iff (sys_rst)
    frame_start_byte_marker |-> $past(rx_active))
    else $error("byte marker outside a frame");
  a_reject_width: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(external_reject_n) |-> (!external_reject_n) [*4])
    else $error("reject pulse shorter than four cycles");
  a_reject_after_da: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(external_reject_n) |-> mark_reg >= 4'h7)
    else $error("reject issued before destination was complete");
endmodule
`default_nettype wire

// File: tb_external_address_detect_iface.sv
// Self-checking bench: receive tap and external comparator joined by a link.
`default_nettype none
module tb_external_address_detect_iface;
  timeunit 1ns;
  timeprecision 100ps;
  import ead_pkg::*;
  localparam logic [47:0] TBL_DA = 48'h0a1b2c3d4e5f;
  localparam int          N_FRAMES = 24;
  logic              clk = 1'b0;
  logic              rx_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [ADDR_W-1:0] ra [2] = '{default: 8'h00};
  logic [DATA_W-1:0] rw [2] = '{default: 32'h0};
  logic [DATA_W-1:0] rr [2];
  logic              wr_s [2] = '{default: 1'b0};
  logic              rd_s [2] = '{default: 1'b0};
  logic              rx_data = 1'b0;
  logic              rx_active = 1'b0;
  logic              rx_phys = 1'b0;
  logic              rx_grp = 1'b0;
  logic [HASH_W-1:0] rx_hash = 6'h00;
  logic              frame_done;
  logic              frame_accept;
  logic              tx_dis;
  logic              rej_pulse;
  int                bad_count = 0;
  int                n_checks = 0;
  int                seed = 15427;
  int                done_n = 0;
  int                pulse_n = 0;
  bit                exp_q [$];

  ead_link_if lnk ();
  ead_dev i_ead_dev (.clk(clk), .sys_rst(sys_rst), .reg_addr(ra[0]),
    .reg_wdata(rw[0]), .reg_wr(wr_s[0]), .reg_rd(rd_s[0]),
    .reg_rdata(rr[0]), .rx_clk(rx_clk), .rx_data(rx_data),
    .rx_active(rx_active), .rx_phys_match(rx_phys),
    .rx_group_match(rx_grp), .rx_hash_idx(rx_hash),
    .frame_done(frame_done), .frame_accept(frame_accept),
    .transmit_disable(tx_dis), .lnk(lnk));
  ead_ext i_ead_ext (.clk(clk), .sys_rst(sys_rst), .reg_addr(ra[1]),
    .reg_wdata(rw[1]), .reg_wr(wr_s[1]), .reg_rd(rd_s[1]),
    .reg_rdata(rr[1]), .reject_pulse(rej_pulse), .lnk(lnk));
  ead_chk i_ead_chk (.clk(clk), .rx_clk(rx_clk), .sys_rst(sys_rst),
    .rx_data(rx_data), .rx_active(rx_active),
    .serial_rx_clock_out(lnk.serial_rx_clock_out),
    .serial_rx_data_out(lnk.serial_rx_data_out),
    .frame_start_byte_marker(lnk.frame_start_byte_marker),
    .external_reject_n(lnk.external_reject_n));

  always #25 clk = ~clk;
  // The offset keeps the two clocks from ever sharing an edge.
  initial begin
    #7;
    forever #62.5 rx_clk = ~rx_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Port 0 is the receive end, port 1 the comparator.
  task automatic wr(input int p, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(posedge clk);
    ra[p] <= a;
    rw[p] <= d;
    wr_s[p] <= 1'b1;
    @(posedge clk);
    wr_s[p] <= 1'b0;
  endtask

  task automatic rd_chk(input int p, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp, input string what);
    @(posedge clk);
    ra[p] <= a;
    rd_s[p] <= 1'b1;
    @(posedge clk);
    rd_s[p] <= 1'b0;
    #1;
    check(what, rr[p], exp);
  endtask

  // Preamble ends in two ones; the body goes out least significant first.
  task automatic send_frame(input logic [47:0] da, input bit ph,
                            input bit gp, input logic [HASH_W-1:0] hx);
    logic [111:0] body;
    body = {$random(seed), $random(seed), da};
    @(posedge rx_clk);
    rx_active <= 1'b1;
    rx_phys <= ph;
    rx_grp <= gp;
    rx_hash <= hx;
    for (int i = 0; i < 16; i++) begin
      rx_data <= (i == 15) || !i[0];
      @(posedge rx_clk);
    end
    for (int j = 0; j < 112; j++) begin
      rx_data <= body[j];
      @(posedge rx_clk);
    end
    rx_active <= 1'b0;
    rx_phys <= 1'b0;
    rx_grp <= 1'b0;
    repeat (20) begin
      rx_data <= 1'($random(seed));
      @(posedge rx_clk);
    end
  endtask

  always @(negedge clk) begin
    if (frame_done === 1'b1 && exp_q.size() > 0) begin
      check("accept", 32'(frame_accept), 32'(exp_q.pop_front()));
      done_n++;
    end
    if (rej_pulse === 1'b1) begin
      pulse_n++;
    end
  end

  initial begin
    logic [31:0] r;
    logic [63:0] laf;
    logic [47:0] da;
    logic [15:0] ctl;
    bit          im;
    bit          rj;
    int          w;
    int          n_rej;
    int          n_acc;
    bit          ex;
    n_rej = 0;
    n_acc = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(0, DEV_CTRL_OFS, {16'h0, CTRL_RESET}, "ctrl reset");
    rd_chk(0, 8'h40, 32'h0, "dev unmapped");
    rd_chk(1, 8'h80, 32'h0, "ext unmapped");
    // Every entry starts invalid so unwritten slots can never hit.
    for (int e = 0; e < TBL_ENTRIES; e++) begin
      wr(1, EXT_TBL_BASE + (8'(e) << TBL_IDX_LSB) + 8'h04, 32'h0);
    end
    wr(1, EXT_TBL_BASE, TBL_DA[31:0]);
    wr(1, EXT_TBL_BASE + 8'h04, {15'h0, 1'b1, TBL_DA[47:32]});
    for (int f = 0; f < N_FRAMES; f++) begin
      r = $random(seed);
      laf = r[17] ? 64'h0 : {$random(seed), $random(seed)};
      da = r[18] ? TBL_DA : 48'({$random(seed), $random(seed)});
      ctl = {r[2] & r[3], 1'b0, r[4], 9'h0, r[7], r[5] & r[6],
             r[0] | r[1], 1'b1};
      wr(0, DEV_CTRL_OFS, 32'h0);
      wr(0, DEV_LAF_LO_OFS, laf[31:0]);
      wr(0, DEV_LAF_HI_OFS, laf[63:32]);
      wr(1, EXT_CTRL_OFS, {30'h0, r[19], r[20] | r[21]});
      wr(0, DEV_CTRL_OFS, {16'h0, ctl});
      rd_chk(0, DEV_CTRL_OFS, {16'h0, ctl}, "ctrl");
      check("tx disable", 32'(tx_dis), 32'(ctl[CTRL_TXDIS_BIT]));
      im = (r[8] & r[9] & !ctl[CTRL_DISABLE_PHYSICAL_ADDR_RX_BIT]) | (r[10] & laf[r[16:11]]);
      rj = ctl[CTRL_SEL_BIT] & (r[20] | r[21]) & (r[19] ? r[18] : !r[18]);
      n_rej += int'(rj);
      ex = !ctl[CTRL_RXDIS_BIT] &
        (ctl[CTRL_PROMISCUOUS_ENABLE_BIT] | im | (ctl[CTRL_SEL_BIT] & !rj));
      n_acc += int'(ex);
      exp_q.push_back(ex);
      repeat (6) @(posedge rx_clk);
      send_frame(da, r[8] & r[9], r[10], r[16:11]);
      for (w = 0; w < 400 && done_n <= f; w++) @(posedge clk);
      check("frame done", 32'(done_n), 32'(f + 1));
      if (done_n <= f) begin
        break;
      end
    end
    r = {16'(N_FRAMES - n_acc), 16'(n_acc)};
    rd_chk(0, DEV_STAT_OFS, r, "frame counts");
    rd_chk(1, EXT_STAT_OFS, 32'(n_rej), "reject count");
    check("reject pulses", 32'(pulse_n), 32'(n_rej));
    results();
  end
endmodule
`default_nettype wire
